// [rtl/dtc_pkg.sv]
package dtc_pkg;

  // register offsets on the byte-wide register port
  localparam logic [7:0] ADDR_CTRL1    = 8'h36;
  localparam logic [7:0] ADDR_DELAYS   = 8'h37;
  localparam logic [7:0] ADDR_CONFIG1  = 8'h40;

  // values after reset
  localparam logic [7:0] RST_CTRL1     = 8'h00;
  localparam logic [7:0] RST_DELAYS    = 8'h00;
  localparam logic       RST_LOCK      = 1'b0;

  // field positions, threshold_adjust_cycle_delays
  localparam int REMOTE1_CODE_LSB      = 0;
  localparam int LOCAL_CODE_LSB        = 3;
  localparam int REMOTE2_LOW_LSB       = 6;

  // field positions, dynamic threshold control register 1
  localparam int REMOTE2_MSB_BIT       = 0;
  localparam int REMOTE1_ENABLE_BIT    = 5;
  localparam int LOCAL_ENABLE_BIT      = 6;
  localparam int REMOTE2_ENABLE_BIT    = 7;

  // field position, configuration register 1
  localparam int LOCK_BIT              = 1;

  // channel count and index of each channel
  localparam int NUM_CHAN              = 3;
  localparam int CH_REMOTE1            = 0;
  localparam int CH_LOCAL              = 1;
  localparam int CH_REMOTE2            = 2;

  // monitoring-cycle counts: code 000 waits, doubled per code step
  localparam int         CNT_W         = 11;
  localparam logic [10:0] DEC_BASE_CYCLES = 11'h004;
  localparam logic [10:0] INC_BASE_CYCLES = 11'h008;
  localparam logic [10:0] CNT_MAX      = 11'h7FF;

  typedef logic [CNT_W-1:0] dtc_count_t;

  // wait in monitoring cycles for a delay code and a direction
  function automatic dtc_count_t dtc_wait(input logic [2:0] code, input logic up);
    dtc_count_t base;
    base = up ? INC_BASE_CYCLES : DEC_BASE_CYCLES;
    return dtc_count_t'(base << code);
  endfunction : dtc_wait

endpackage : dtc_pkg

// [rtl/dtc_chan_if.sv]
// one temperature channel between the register bank and its adjust timer
interface dtc_chan_if;
  logic       enable;
  logic [2:0] code;
  logic       want_up;
  logic       want_down;
  logic       adjust_up;
  logic       adjust_down;

  modport ctrl  (output enable, output code, output want_up, output want_down,
                 input adjust_up, input adjust_down);
  modport timer (input enable, input code, input want_up, input want_down,
                 output adjust_up, output adjust_down);
endinterface : dtc_chan_if

// [rtl/dtc_adjust_timer.sv]
module dtc_adjust_timer (
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   tick,
  dtc_chan_if.timer   chan
);

  dtc_pkg::dtc_count_t elapsed;
  logic                go_down;
  logic                go_up;

  // decrease has priority: an earlier fan start is the safer move
  always_comb begin
    go_down = chan.enable && chan.want_down &&
              (elapsed >= dtc_pkg::dtc_wait(chan.code, 1'b0)); // R6 R8 R9 R12
    go_up   = chan.enable && chan.want_up && !go_down &&
              (elapsed >= dtc_pkg::dtc_wait(chan.code, 1'b1)); // R7 R8 R9 R12
  end

  // next wait count; the caller stops at the top so the count never wraps
  function automatic dtc_pkg::dtc_count_t dtc_count_next(input dtc_pkg::dtc_count_t v);
    return dtc_pkg::dtc_count_t'(v + 11'h001);
  endfunction : dtc_count_next

  // completed monitoring cycles since the last adjustment, saturating
  always_ff @(posedge clk) begin
    if (rst || !chan.enable) begin
      elapsed <= '0; // R12
    end else if (go_down || go_up) begin
      elapsed <= '0; // R8
    end else if (tick && elapsed != dtc_pkg::CNT_MAX) begin
      elapsed <= dtc_count_next(elapsed);
    end
  end

  // one-cycle adjust pulses
  always_ff @(posedge clk) begin
    if (rst) begin
      chan.adjust_down <= 1'b0;
      chan.adjust_up   <= 1'b0;
    end else begin
      chan.adjust_down <= go_down;
      chan.adjust_up   <= go_up;
    end
  end

  chk_down_wait_met: assert property (@(posedge clk) disable iff (rst) // R6
    chan.adjust_down |-> $past(elapsed) >= dtc_pkg::dtc_wait($past(chan.code), 1'b0))
    else $error("decrease issued before its wait elapsed");

  chk_up_wait_met: assert property (@(posedge clk) disable iff (rst) // R7
    chan.adjust_up |-> $past(elapsed) >= dtc_pkg::dtc_wait($past(chan.code), 1'b1))
    else $error("increase issued before its wait elapsed");

  chk_adjust_restarts_count: assert property (@(posedge clk) disable iff (rst) // R8
    (chan.adjust_up || chan.adjust_down) |-> elapsed == 11'h000)
    else $error("wait count not restarted after adjustment");

  chk_disabled_no_adjust: assert property (@(posedge clk) disable iff (rst) // R12
    !chan.enable |=> !chan.adjust_up && !chan.adjust_down)
    else $error("adjustment on a disabled channel");

  chk_code7_dec_wait: assert property (@(posedge clk) disable iff (rst) // R9
    chan.enable && chan.want_down && chan.code == 3'h7 && elapsed == 11'h1FF && !tick
    |=> !chan.adjust_down)
    else $error("code 111 decrease fired before 512 cycles");

endmodule : dtc_adjust_timer

// [rtl/dtc_delay_config.sv]
// How it works
// R1 - delay register at 0x37, eight bits read/write, zero after reset.
// R2 - once locked, writes to the delay register are ignored.
// R3 - bits 2:0 hold the first remote channel delay code.
// R4 - bits 5:3 hold the local channel delay code.
// R5 - bits 7:6 are remote2 code low bits; its top bit lives in 0x36.
// R6 - decrease wait is 4 cycles at code 000, doubling per step.
// R7 - increase wait is twice the decrease wait, 8 cycles at code 000.
// R8 - each channel counts monitoring cycles and waits its own delay before adjusting.
// R9 - code 111 waits 512 cycles down and 1024 cycles up.
// R10 - bit 0 of register 0x36 is the remote2 delay code top bit.
// R11 - lock bit writes once; lockable registers stay read-only until reset.
// R12 - channel enable bits gate adjustment; a disabled channel's code has no effect.
module dtc_delay_config (
  input  wire logic       SYS_CLK,
  input  wire logic       RESET,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  input  wire logic       MONITOR_TICK,
  input  wire logic [2:0] WANT_UP,
  input  wire logic [2:0] WANT_DOWN,
  output logic      [2:0] ADJUST_UP,
  output logic      [2:0] ADJUST_DOWN,
  output logic            CONFIG_LOCKED
);

  logic [7:0] delay_codes;
  logic [7:0] ctrl1;
  logic       locked;
  logic [7:0] next_rdata;
  logic       wr_delays;
  logic       wr_ctrl1;
  logic       wr_config1;
  logic [2:0] chan_code   [dtc_pkg::NUM_CHAN];
  logic [2:0] chan_enable;

  // address match shared by the three write decodes
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
    return addr == offset;
  endfunction : reg_hit

  // write decode; every lockable write is dropped while locked
  // configuration register 1 is lockable too, so the lock bit cannot be rewritten
  assign wr_delays  = REG_WR && reg_hit(REG_ADDR, dtc_pkg::ADDR_DELAYS)  && !locked; // R2
  assign wr_ctrl1   = REG_WR && reg_hit(REG_ADDR, dtc_pkg::ADDR_CTRL1)   && !locked; // R11
  assign wr_config1 = REG_WR && reg_hit(REG_ADDR, dtc_pkg::ADDR_CONFIG1) && !locked; // R11

  // delay code register
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      delay_codes <= dtc_pkg::RST_DELAYS; // R1
    end else if (wr_delays) begin
      delay_codes <= REG_WDATA; // R1
    end
  end

  // control register 1: remote2 top code bit and channel enables
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ctrl1 <= dtc_pkg::RST_CTRL1;
    end else if (wr_ctrl1) begin
      ctrl1 <= REG_WDATA;
    end
  end

  // lock is write-once: only reset brings it back to zero
  // no write path clears it, so a stray write cannot unlock the bank
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      locked <= dtc_pkg::RST_LOCK;
    end else if (wr_config1 && REG_WDATA[dtc_pkg::LOCK_BIT]) begin
      locked <= 1'b1; // R11
    end
  end

  // lock level straight from its flip-flop
  assign CONFIG_LOCKED = locked;

  // read mux; unmapped offsets read as zero
  // gating with the strobe keeps the data at zero between reads
  always_comb begin
    next_rdata = 8'h00;
    if (REG_RD) begin
      case (REG_ADDR)
        dtc_pkg::ADDR_DELAYS:  next_rdata = delay_codes; // R1
        dtc_pkg::ADDR_CTRL1:   next_rdata = ctrl1;
        dtc_pkg::ADDR_CONFIG1: next_rdata = {6'h00, locked, 1'b0};
        default:               next_rdata = 8'h00;
      endcase
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= next_rdata;
    end
  end

  // per-channel code and enable extraction
  // remote2 draws its top bit from control register 1, so a write to either register moves it
  always_comb begin
    chan_code[dtc_pkg::CH_REMOTE1] = delay_codes[dtc_pkg::REMOTE1_CODE_LSB +: 3]; // R3
    chan_code[dtc_pkg::CH_LOCAL]   = delay_codes[dtc_pkg::LOCAL_CODE_LSB +: 3];   // R4
    chan_code[dtc_pkg::CH_REMOTE2] = {ctrl1[dtc_pkg::REMOTE2_MSB_BIT],            // R10
                                      delay_codes[dtc_pkg::REMOTE2_LOW_LSB +: 2]}; // R5
    chan_enable[dtc_pkg::CH_REMOTE1] = ctrl1[dtc_pkg::REMOTE1_ENABLE_BIT]; // R12
    chan_enable[dtc_pkg::CH_LOCAL]   = ctrl1[dtc_pkg::LOCAL_ENABLE_BIT];   // R12
    chan_enable[dtc_pkg::CH_REMOTE2] = ctrl1[dtc_pkg::REMOTE2_ENABLE_BIT]; // R12
  end

  // one independent adjust timer per channel
  for (genvar i = 0; i < dtc_pkg::NUM_CHAN; i++) begin : g_chan
    dtc_chan_if chan ();

    assign chan.enable    = chan_enable[i];
    assign chan.code      = chan_code[i];
    assign chan.want_up   = WANT_UP[i];
    assign chan.want_down = WANT_DOWN[i];
    assign ADJUST_UP[i]   = chan.adjust_up;
    assign ADJUST_DOWN[i] = chan.adjust_down;

    dtc_adjust_timer u_timer (
      .clk  (SYS_CLK),
      .rst  (RESET),
      .tick (MONITOR_TICK),
      .chan (chan.timer)
    ); // R8

    // pulses at the bank's pins, per channel
    chk_adjust_needs_enable: assert property (@(posedge SYS_CLK) disable iff (RESET) // R12
      (ADJUST_UP[i] || ADJUST_DOWN[i]) |-> $past(chan_enable[i]))
      else $error("adjust pulse without the channel enabled");

    chk_adjust_needs_want: assert property (@(posedge SYS_CLK) disable iff (RESET) // R8
      (!ADJUST_DOWN[i] || $past(WANT_DOWN[i])) && (!ADJUST_UP[i] || $past(WANT_UP[i])))
      else $error("adjust pulse without a request from the loop");

    chk_adjust_one_cycle: assert property (@(posedge SYS_CLK) disable iff (RESET) // R8
      (ADJUST_UP[i] || ADJUST_DOWN[i]) |=> !ADJUST_UP[i] && !ADJUST_DOWN[i])
      else $error("adjust pulse longer than one cycle");
  end

  // register bank checks
  chk_locked_delays_hold: assert property (@(posedge SYS_CLK) disable iff (RESET) // R2
    locked && REG_WR && REG_ADDR == dtc_pkg::ADDR_DELAYS |=> $stable(delay_codes))
    else $error("delay register changed while locked");

  chk_delay_write_lands: assert property (@(posedge SYS_CLK) disable iff (RESET) // R1
    !locked && REG_WR && REG_ADDR == dtc_pkg::ADDR_DELAYS |=> delay_codes == $past(REG_WDATA))
    else $error("delay register write lost");

  chk_delay_read_back: assert property (@(posedge SYS_CLK) disable iff (RESET) // R1
    REG_RD && REG_ADDR == dtc_pkg::ADDR_DELAYS |=> REG_RDATA == $past(delay_codes))
    else $error("delay register read mismatch");

  chk_lock_stays_set: assert property (@(posedge SYS_CLK) disable iff (RESET) // R11
    locked |=> locked)
    else $error("lock bit cleared without reset");

  chk_locked_ctrl_hold: assert property (@(posedge SYS_CLK) disable iff (RESET) // R11
    locked && REG_WR && REG_ADDR == dtc_pkg::ADDR_CTRL1 |=> $stable(ctrl1))
    else $error("control register changed while locked");

  chk_remote2_code_map: assert property (@(posedge SYS_CLK) disable iff (RESET) // R5
    chan_code[dtc_pkg::CH_REMOTE2] == {ctrl1[0], delay_codes[7:6]})
    else $error("remote2 code assembled wrongly");

  chk_field_map: assert property (@(posedge SYS_CLK) disable iff (RESET) // R3
    chan_code[dtc_pkg::CH_REMOTE1] == delay_codes[2:0] && chan_code[dtc_pkg::CH_LOCAL] == delay_codes[5:3])
    else $error("remote1 or local code mapped wrongly");

  chk_idle_read_zero: assert property (@(posedge SYS_CLK) disable iff (RESET) // R1
    !REG_RD |=> REG_RDATA == 8'h00)
    else $error("read data present without a read");

  // reset is checked without a disable, so the cleared state itself is seen
  chk_reset_clears_bank: assert property (@(posedge SYS_CLK) // R1
    RESET |=> delay_codes == dtc_pkg::RST_DELAYS && ctrl1 == dtc_pkg::RST_CTRL1 &&
              locked == dtc_pkg::RST_LOCK && REG_RDATA == 8'h00 &&
              ADJUST_UP == 3'h0 && ADJUST_DOWN == 3'h0)
    else $error("bank not cleared by reset");

  chk_ctrl_write_lands: assert property (@(posedge SYS_CLK) disable iff (RESET) // R10
    !locked && REG_WR && REG_ADDR == dtc_pkg::ADDR_CTRL1 |=> ctrl1 == $past(REG_WDATA))
    else $error("control register write lost");

  chk_ctrl_read_back: assert property (@(posedge SYS_CLK) disable iff (RESET) // R10
    REG_RD && REG_ADDR == dtc_pkg::ADDR_CTRL1 |=> REG_RDATA == $past(ctrl1))
    else $error("control register read mismatch");

  chk_lock_read_back: assert property (@(posedge SYS_CLK) disable iff (RESET) // R11
    REG_RD && REG_ADDR == dtc_pkg::ADDR_CONFIG1 |=> REG_RDATA == {6'h00, $past(locked), 1'b0})
    else $error("lock bit read mismatch");

  chk_unmapped_read_zero: assert property (@(posedge SYS_CLK) disable iff (RESET) // R1
    REG_RD && REG_ADDR != dtc_pkg::ADDR_DELAYS && REG_ADDR != dtc_pkg::ADDR_CTRL1 &&
    REG_ADDR != dtc_pkg::ADDR_CONFIG1 |=> REG_RDATA == 8'h00)
    else $error("unmapped read returned data");

  chk_lock_write_sets: assert property (@(posedge SYS_CLK) disable iff (RESET) // R11
    !locked && REG_WR && REG_ADDR == dtc_pkg::ADDR_CONFIG1 &&
    REG_WDATA[dtc_pkg::LOCK_BIT] |=> locked)
    else $error("lock write did not set the lock");

  chk_lock_needs_write: assert property (@(posedge SYS_CLK) disable iff (RESET) // R11
    !locked && !(REG_WR && REG_ADDR == dtc_pkg::ADDR_CONFIG1) |=> !locked)
    else $error("lock set without a write");

  chk_delays_hold_otherwise: assert property (@(posedge SYS_CLK) disable iff (RESET) // R1
    !(REG_WR && REG_ADDR == dtc_pkg::ADDR_DELAYS) |=> $stable(delay_codes))
    else $error("delay register changed without a write");

  chk_ctrl_hold_otherwise: assert property (@(posedge SYS_CLK) disable iff (RESET) // R10
    !(REG_WR && REG_ADDR == dtc_pkg::ADDR_CTRL1) |=> $stable(ctrl1))
    else $error("control register changed without a write");

endmodule : dtc_delay_config

// [verification/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
  $display("BAD %s expected %0h seen %0h", nm, exp, got); n_errors++; end end

  logic       sys_clk;
  logic       reset;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       monitor_tick;
  logic [2:0] want_up;
  logic [2:0] want_down;
  logic [2:0] adjust_up;
  logic [2:0] adjust_down;
  logic       config_locked;
  int         n_errors;
  int         compares;

  dtc_delay_config dut (.SYS_CLK(sys_clk), .RESET(reset), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .MONITOR_TICK(monitor_tick),
    .WANT_UP(want_up), .WANT_DOWN(want_down), .ADJUST_UP(adjust_up), .ADJUST_DOWN(adjust_down),
    .CONFIG_LOCKED(config_locked));

  // free-running system clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data is sampled in the single cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // disable first so the channel's count starts from zero
  task automatic set_chan(input int ch, input logic [2:0] code, input logic en);
    logic [7:0] d36;
    d36 = 8'h00;
    wr(8'h36, 8'h00);
    wr(8'h37, (ch == 2) ? {code[1:0], 6'h00} : (ch == 1) ? {2'h0, code, 3'h0} : {5'h00, code});
    d36[5+ch] = en;
    if (ch == 2) d36[0] = code[2];
    wr(8'h36, d36);
  endtask : set_chan

  // returns the tick count at which the adjust pulse appeared, 0 if none
  task automatic count_ticks(input int ch, input logic up, input int lim, output int got);
    got = 0;
    for (int n = 1; n <= lim && got == 0; n++) begin
      @(posedge sys_clk) monitor_tick <= 1'b1;
      @(posedge sys_clk) monitor_tick <= 1'b0;
      repeat (3) begin
        @(posedge sys_clk);
        #1 if ((up ? adjust_up[ch] : adjust_down[ch]) === 1'b1) got = n;
      end
    end
  endtask : count_ticks

  task automatic measure(input int ch, input logic [2:0] code, input logic up);
    int got;
    int exp;
    exp = (up ? 8 : 4) << code;
    set_chan(ch, code, 1'b1);
    @(posedge sys_clk);
    want_up[ch] <= up; want_down[ch] <= ~up;
    count_ticks(ch, up, exp + 2, got);
    `CHK("adjust wait ticks", exp, got)
    @(posedge sys_clk);
    want_up <= 3'h0; want_down <= 3'h0;
  endtask : measure

  task automatic scen_reset_and_rw;
    logic [7:0] d;
    rd(8'h37, d); `CHK("delays reset", 8'h00, d)
    rd(8'h36, d); `CHK("ctrl1 reset", 8'h00, d)
    rd(8'h40, d); `CHK("config1 reset", 8'h00, d)
    wr(8'h37, 8'hA5);
    rd(8'h37, d); `CHK("delays readback", 8'hA5, d)
    @(posedge sys_clk) #1 `CHK("rdata idle", 8'h00, reg_rdata)
    wr(8'h55, 8'hFF);
    rd(8'h55, d); `CHK("unmapped read", 8'h00, d)
  endtask : scen_reset_and_rw

  // every code in both directions on one channel, then field placement on the others
  task automatic scen_timing;
    for (int c = 0; c < 8; c++) begin
      measure(1, c[2:0], 1'b0);
      measure(1, c[2:0], 1'b1);
    end
    measure(0, 3'h3, 1'b0);
    measure(0, 3'h1, 1'b1);
    measure(2, 3'h5, 1'b0);
    measure(2, 3'h2, 1'b1);
  endtask : scen_timing

  task automatic scen_disabled;
    int got;
    set_chan(1, 3'h0, 1'b0);
    @(posedge sys_clk) want_down[1] <= 1'b1;
    count_ticks(1, 1'b0, 10, got);
    `CHK("disabled channel pulse", 0, got)
    @(posedge sys_clk) want_down <= 3'h0;
  endtask : scen_disabled

  task automatic scen_lock;
    logic [7:0] d;
    wr(8'h37, 8'h5A);
    wr(8'h36, 8'h40);
    wr(8'h40, 8'h02);
    @(posedge sys_clk) #1 `CHK("locked flag", 1'b1, config_locked)
    wr(8'h37, 8'hFF);
    rd(8'h37, d); `CHK("locked delays", 8'h5A, d)
    wr(8'h36, 8'h00);
    rd(8'h36, d); `CHK("locked ctrl1", 8'h40, d)
    wr(8'h40, 8'h00);
    rd(8'h40, d); `CHK("lock stays", 8'h02, d)
  endtask : scen_lock

  // hang guard sized well above the longest measured waits
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    stop_test();
  end

  // reset, then each scenario in turn; stop_test gives the verdict
  initial begin
    n_errors = 0; compares = 0;
    reset = 1'b1; reg_addr = 8'h00; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
    monitor_tick = 1'b0; want_up = 3'h0; want_down = 3'h0;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    scen_reset_and_rw();
    scen_timing();
    scen_disabled();
    scen_lock();
    stop_test();
  end
endmodule : tb_top
